/* bench/tcc_engine_model.sv */
`timescale 1ns/1ns
module tcc_engine_model
#(
	parameter int CONV = 10
)
(
	// Control
	input wire logic clock,
	input wire logic sensorOn,
	// Engine results
	output logic [9:0] tempSample,
	output logic [5:0] finalAnalogTrim,
	output logic [4:0] finalDigitalTrim
);
	int cnt = 0;
	initial tempSample = 10'h155;
	// Toggles when idle so a stale sample cannot match
	always @(posedge clock)
	begin
		cnt <= sensorOn ? cnt + 1 : 0;
		tempSample <= !sensorOn ? ~tempSample :
			(cnt < CONV * 3 / 2 ? 10'h100 : 10'h203);
	end
	assign finalAnalogTrim = 6'h25;
	assign finalDigitalTrim = 5'h03;
endmodule // tcc_engine_model

/* bench/tcc_top_bench.sv */
`timescale 1ns/1ns
module tcc_top_bench;
	logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic onBattery = 0, batteryLow = 0, pready, pslverr, lastErr;
	logic [7:0] paddr = '0, factoryCurvature = 8'h46;
	logic [31:0] pwdata = '0, prdata;
	logic [4:0] factoryGain = '0, finalDigitalTrim, oscDigitalCode;
	logic [5:0] factoryAnalogTrim = '0, finalAnalogTrim, oscAnalogCode;
	logic [1:0] factoryDigitalTrim = 2'h1;
	logic [9:0] tempSample, tempResult;
	logic sensorOn, compActive;
	logic [13:0] oscAnalogScaled;
	int err_count = 0, num_checks = 0;
	logic [5:0] trims [5] = '{6'h3f, 6'h00, 6'h21, 6'h20, 6'h1f};
	logic [4:0] gains [5] = '{5'h00, 5'h08, 5'h0f, 5'h10, 5'h1f};
	tcc_top #(.CONV_CYCLES(36'h00000000a), .PERIOD_LONG_CYCLES(36'h0000001f4),
		.PERIOD_SHORT_CYCLES(36'h0000000c8)) dut
	(
		.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .factoryCurvature, .factoryGain,
		.factoryAnalogTrim, .factoryDigitalTrim, .onBattery, .batteryLow,
		.tempSample, .finalAnalogTrim, .finalDigitalTrim, .sensorOn,
		.tempResult, .compActive, .oscAnalogCode, .oscDigitalCode,
		.oscAnalogScaled
	);
	tcc_engine_model #(.CONV(10)) eng
	(
		.clock, .sensorOn, .tempSample, .finalAnalogTrim, .finalDigitalTrim
	);
	initial
	begin
		forever #50 clock = ~clock;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		lastErr = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50)
		begin
			err_count++;
			stop_test();
		end
	endtask
	// Counts settled edges until sensorOn reaches v
	task automatic waitOn(input logic v, output int n);
		n = 0;
		while (sensorOn !== v)
		begin
			@(posedge clock);
			#1;
			n++;
			if (n > 2000)
			begin
				err_count++;
				stop_test();
			end
		end
	endtask
	task automatic quiet(output int n);
		n = 0;
		repeat (603)
		begin
			@(posedge clock);
			n += int'(sensorOn !== 1'b0);
		end
		n -= 3;
		if (n < 0)
			n = 0;
	endtask
	initial
	begin
		logic [31:0] r;
		int n, a, s, ppm;
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clock);
			rst_n <= 0;
			factoryAnalogTrim <= trims[i];
			factoryGain <= gains[i];
			repeat (5) @(posedge clock);
			rst_n <= 1;
			repeat (4) @(posedge clock);
			#1;
			ppm = 32 - int'(trims[i]);
			s = gains[i][4] ? 17 + int'(gains[i][3:0]) :
				(gains[i] > 5'h08 ? 8 : 16 - int'(gains[i]));
			check({18'h0, oscAnalogScaled},
				{18'h0, 14'(ppm * s)});
			check({26'h0, oscAnalogCode}, {26'h0, trims[i]});
			check({27'h0, oscDigitalCode}, 32'h1);
			apb(0, 6'h0d, 32'h0, r);
			check(r, {27'h0, factoryGain});
			apb(0, 6'h0b, 32'h0, r);
			check(r, {24'h0, 2'h1, trims[i]});
			apb(1, 6'h0c, 32'hff, r);
			apb(1, 6'h0d, 32'h3f, r);
			apb(0, 6'h0c, 32'h0, r);
			check(r, {24'h0, factoryCurvature});
			apb(0, 6'h0d, 32'h0, r);
			check(r, {24'h0, 3'h1, factoryGain});
			apb(0, 6'h3f, 32'h0, r);
			check({31'h0, lastErr}, 32'h1);
		end
		apb(1, 6'h0d, 32'h80, r);
		waitOn(1, n);
		check(n, 1);
		waitOn(0, n);
		check(n, 20);
		check({22'h0, tempResult}, 32'h181);
		check({26'h0, oscAnalogCode}, 32'h25);
		check({27'h0, oscDigitalCode}, 32'h3);
		apb(0, 6'h20, 32'h0, r);
		check(r, 32'h181);
		apb(1, 6'h0d, 32'h0, r);
		repeat (3) @(posedge clock);
		#1;
		check({26'h0, oscAnalogCode}, 32'h1f);
		@(posedge clock);
		onBattery <= 1;
		for (int k = 0; k < 2; k++)
		begin
			apb(1, 6'h0d, k ? 32'h60 : 32'h40, r);
			// Let a cycle already running finish before timing
			waitOn(0, n);
			waitOn(1, n);
			waitOn(0, a);
			waitOn(1, n);
			check(a, 20);
			check(a + n, k ? 200 : 500);
		end
		apb(1, 6'h0d, 32'h20, r);
		quiet(n);
		check(n, 0);
		@(posedge clock);
		batteryLow <= 1;
		apb(1, 6'h0d, 32'h60, r);
		quiet(n);
		check(n, 0);
		check({31'h0, compActive}, 32'h0);
		apb(0, 6'h21, 32'h0, r);
		check(r, 32'h18);
		stop_test();
	end
endmodule // tcc_top_bench

/* bench/tcc_top_sva.sv */
`timescale 1ns/1ns
module tcc_top_sva
#(
	parameter logic [35:0] CONV_CYCLES = 36'h00000000a
)
(
	// Clock, reset, register port
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Presets and supply
	input wire logic [7:0] factoryCurvature,
	input wire logic [4:0] factoryGain,
	input wire logic [5:0] factoryAnalogTrim,
	input wire logic onBattery,
	input wire logic batteryLow,
	// Sensing and oscillator
	input wire logic [5:0] finalAnalogTrim,
	input wire logic sensorOn,
	input wire logic [9:0] tempResult,
	input wire logic compActive,
	input wire logic [5:0] oscAnalogCode
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic [35:0] hiCnt_q;
	logic [2:0] upCnt_q;
	logic rd;
	assign rd = pready && !pwrite;
	// Presets are caught only after release, so wait a few edges
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			hiCnt_q <= '0;
			upCnt_q <= '0;
		end
		else
		begin
			hiCnt_q <= sensorOn ? hiCnt_q + 36'h1 : '0;
			upCnt_q <= upCnt_q + {2'h0, upCnt_q != 3'h4};
		end
	a_curv_read: assert property (
		rd && paddr[7:2] == 6'h0c |-> prdata == {24'h0, factoryCurvature})
		else $error("curvature read wrong");
	a_gain_keep: assert property (
		rd && paddr[7:2] == 6'h0d |-> prdata[4:0] == factoryGain)
		else $error("gain bits changed");
	a_init_source: assert property (
		upCnt_q == 3'h4 && !compActive && !$past(compActive) &&
		!$past(compActive, 2) |-> oscAnalogCode == factoryAnalogTrim)
		else $error("initial trim not used");
	a_final_source: assert property (
		compActive && $past(compActive) && $past(compActive, 2) |->
		oscAnalogCode == finalAnalogTrim) else $error("final trim not used");
	a_conv_length: assert property (
		$fell(sensorOn) && compActive |-> hiCnt_q == 2 * CONV_CYCLES)
		else $error("conversion cycle length wrong");
	a_sense_gate: assert property (
		!compActive && !$past(compActive) |-> !sensorOn)
		else $error("sensing while not allowed");
	a_low_off: assert property (
		onBattery && batteryLow && $past(onBattery && batteryLow) |->
		!compActive) else $error("compensation on low battery");
	a_result_hold: assert property (
		!$stable(tempResult) |-> $fell(sensorOn))
		else $error("result changed mid cycle");
	c_conv: cover property ($fell(sensorOn) && compActive);
	c_batt: cover property (onBattery && sensorOn);
	c_low: cover property (onBattery && batteryLow);
endmodule // tcc_top_sva

bind tcc_top tcc_top_sva #(.CONV_CYCLES(CONV_CYCLES)) chk
(
	.clock, .rst_n, .pwrite, .paddr, .prdata, .pready,
	.factoryCurvature, .factoryGain, .factoryAnalogTrim, .onBattery,
	.batteryLow, .finalAnalogTrim, .sensorOn, .tempResult, .compActive,
	.oscAnalogCode
);

/* common/tcc_params.svh */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register indices; byte address is four times the index
`define TCC_IDX_INIT_TRIM 6'h0b
`define TCC_IDX_CURVATURE 6'h0c
`define TCC_IDX_CTRL_GAIN 6'h0d
`define TCC_IDX_TEMP 6'h20
`define TCC_IDX_STATUS 6'h21

// Control and gain register fields
`define TCC_CTRL_TSE_BIT 7
`define TCC_CTRL_BSE_BIT 6
`define TCC_CTRL_BSR_BIT 5
`define TCC_GAIN_MSB 4

// Reset values of the software-writable control bits
`define TCC_TSE_RESET 1'b0
`define TCC_BSE_RESET 1'b0
`define TCC_BSR_RESET 1'b0

// Curvature is stored as magnitude times this factor
`define TCC_CURV_SCALE 2048

// Analog trim code with value zero ppm, gain in sixteenths
`define TCC_TRIM_ZERO 7'h20
`define TCC_GAIN_UNITY 6'h10
`define TCC_GAIN_MIN 6'h08

// Timing
`define TCC_CLK_HZ 64'd10000000
`define TCC_CONV_TIME_US 64'd22000
`define TCC_PERIOD_LONG_S 64'd600
`define TCC_PERIOD_SHORT_S 64'd60
`define TCC_CONV_CYCLES (`TCC_CONV_TIME_US * `TCC_CLK_HZ / 64'd1000000)
`define TCC_PERIOD_LONG_CYCLES (`TCC_PERIOD_LONG_S * `TCC_CLK_HZ)
`define TCC_PERIOD_SHORT_CYCLES (`TCC_PERIOD_SHORT_S * `TCC_CLK_HZ)

`endif

/* common/tcc_pkg.sv */
package tcc_pkg;

	typedef enum logic [1:0]
	{
		TCC_IDLE = 2'b00,
		TCC_CONV_A = 2'b01,
		TCC_CONV_B = 2'b10
	} tcc_seq_t;

	typedef struct packed
	{
		logic loaded;
		logic temp_sense_enable;
		logic bse;
		logic bsr;
		logic [4:0] gain;
		logic [7:0] curvature;
		logic [5:0] initAnalog;
		logic [1:0] initDigital;
		tcc_seq_t seq;
		logic [35:0] convCnt;
		logic [35:0] periodCnt;
		logic [9:0] sampleA;
		logic [9:0] tempResult;
		logic resultValid;
		logic sensorOn;
		logic compActive;
		logic [5:0] oscAnalog;
		logic [4:0] oscDigital;
		logic [13:0] oscScaled;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tcc_regs_t;

endpackage

/* rtl/tcc_top.sv */
// What this block does
// - A six-bit analog trim code above 100000 is a negative step count in ppm, 100000 giving 0 and all ones giving -31.
// - The cold curvature coefficient is held as its magnitude times 2048 in plain binary.
// - Curvature and gain are loaded from factory presets after power-up and host writes never change them.
// - A write to the control and gain register changes only its three top bits, the five gain bits keep their factory value.
// - Sensing enable resets to 0 and, when set on main supply, turns on sensor, converter and final trim adjustment.
// - With sensing disabled the oscillator is steered by the initial analog and digital trim values.
// - Setting sensing enable runs two conversions at once, then again every minute, and stores their average as the temperature result.
// - On backup supply sensing and compensation run only when the backup enable is 1, which resets to 0.
// - Backup compensation is forced off while the battery is below 2.7V, whatever the backup enable says.
// - On backup the sensing repeats every 10 minutes with period select 0 and every minute with 1, never when disabled.
// - Each conversion takes the same time, about 22ms, on either supply.
// - Gain code 00000 is a step scale of 1, 00001..01000 lower it by 1/16 to 0.5, 10000..11111 raise it by 1/16 to 2.
// - Each analog trim step is scaled by the gain so the nominal step stays 1ppm.
`timescale 1ns/1ns
`include "tcc_params.svh"

module tcc_top
#(
	parameter int ADDR_W = 8,
	parameter logic [35:0] CONV_CYCLES = 36'(`TCC_CONV_CYCLES),
	parameter logic [35:0] PERIOD_LONG_CYCLES = 36'(`TCC_PERIOD_LONG_CYCLES),
	parameter logic [35:0] PERIOD_SHORT_CYCLES =
		36'(`TCC_PERIOD_SHORT_CYCLES)
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Factory presets
	input wire logic [7:0] factoryCurvature,
	input wire logic [4:0] factoryGain,
	input wire logic [5:0] factoryAnalogTrim,
	input wire logic [1:0] factoryDigitalTrim,
	// Supply state
	input wire logic onBattery,
	input wire logic batteryLow,
	// Temperature converter and compensation engine
	input wire logic [9:0] tempSample,
	input wire logic [5:0] finalAnalogTrim,
	input wire logic [4:0] finalDigitalTrim,
	output logic sensorOn,
	output logic [9:0] tempResult,
	// Oscillator control
	output logic compActive,
	output logic [5:0] oscAnalogCode,
	output logic [4:0] oscDigitalCode,
	output logic [13:0] oscAnalogScaled
);

	tcc_pkg::tcc_regs_t q;
	tcc_pkg::tcc_regs_t d;

	logic [5:0] regIdx;
	logic accessFirst;
	logic accessDone;
	logic mapped;
	logic [31:0] readWord;
	logic sensingAllowed;
	logic tseRise;
	logic periodDone;
	logic [35:0] periodLen;
	logic [5:0] analogSel;
	logic [4:0] digitalSel;
	logic signed [6:0] trimPpm;
	logic [5:0] gainSixteenths;
	logic signed [13:0] scaledSixteenths;

	tcc_trim_scale u_scale
	(
		.trimCode(analogSel),
		.gainCode(q.gain),
		.trimPpm(trimPpm),
		.gainSixteenths(gainSixteenths),
		.scaledSixteenths(scaledSixteenths)
	);

	assign regIdx = paddr[7:2];

	always_comb
	begin
		d = q;

		// Presets are caught one edge after reset release, never by the reset
		if (!q.loaded)
		begin
			d.loaded = 1'b1;
			d.curvature = factoryCurvature;
			d.gain = factoryGain;
			d.initAnalog = factoryAnalogTrim;
			d.initDigital = factoryDigitalTrim;
		end

		// One wait state: data and answer are registered
		accessFirst = psel & penable & ~q.pready;
		accessDone = psel & penable & q.pready;
		mapped = 1'b1;
		readWord = 32'h0000_0000;
		case (regIdx)
			`TCC_IDX_INIT_TRIM:
				readWord = {24'h00_0000, q.initDigital, q.initAnalog};
			`TCC_IDX_CURVATURE:
				readWord = {24'h00_0000, q.curvature};
			`TCC_IDX_CTRL_GAIN:
				readWord = {24'h00_0000, q.temp_sense_enable, q.bse, q.bsr, q.gain};
			`TCC_IDX_TEMP:
				readWord = {22'h00_0000, q.tempResult};
			`TCC_IDX_STATUS:
				readWord = {27'h000_0000, onBattery, q.resultValid,
					q.compActive, q.sensorOn, q.seq != tcc_pkg::TCC_IDLE};
			default:
				mapped = 1'b0;
		endcase
		d.pready = accessFirst;
		d.pslverr = accessFirst & ~mapped;
		d.prdata = (accessFirst && !pwrite) ? readWord : 32'h0000_0000;

		// Read-only registers take writes silently; gain bits never change
		if (accessDone && pwrite && regIdx == `TCC_IDX_CTRL_GAIN)
		begin
			d.temp_sense_enable = pwdata[`TCC_CTRL_TSE_BIT];
			d.bse = pwdata[`TCC_CTRL_BSE_BIT];
			d.bsr = pwdata[`TCC_CTRL_BSR_BIT];
		end
		// On main supply enable taking effect starts a cycle at once, not a period later
		tseRise = q.temp_sense_enable & ~q.compActive;

		// On backup only the backup enable counts, and only on a healthy cell
		if (onBattery)
			sensingAllowed = q.bse & ~batteryLow;
		else
			sensingAllowed = q.temp_sense_enable;
		d.compActive = sensingAllowed;

		if (onBattery && !q.bsr)
			periodLen = PERIOD_LONG_CYCLES;
		else
			periodLen = PERIOD_SHORT_CYCLES;
		periodDone = q.periodCnt >= periodLen - 36'h1;

		if (!sensingAllowed)
		begin
			// Dropping the enable aborts any half-done cycle
			d.seq = tcc_pkg::TCC_IDLE;
			d.sensorOn = 1'b0;
			d.convCnt = '0;
			d.periodCnt = '0;
		end
		else
		begin
			d.periodCnt = q.periodCnt + 36'h1;
			case (q.seq)
				tcc_pkg::TCC_IDLE:
				begin
					if ((tseRise && !onBattery) || periodDone)
					begin
						d.seq = tcc_pkg::TCC_CONV_A;
						d.sensorOn = 1'b1;
						d.convCnt = '0;
						d.periodCnt = '0;
					end
				end
				tcc_pkg::TCC_CONV_A:
				begin
					if (q.convCnt >= CONV_CYCLES - 36'h1)
					begin
						d.sampleA = tempSample;
						d.convCnt = '0;
						d.seq = tcc_pkg::TCC_CONV_B;
					end
					else
						d.convCnt = q.convCnt + 36'h1;
				end
				tcc_pkg::TCC_CONV_B:
				begin
					if (q.convCnt >= CONV_CYCLES - 36'h1)
					begin
						d.tempResult = 10'(({1'b0, q.sampleA} +
							{1'b0, tempSample}) >> 1);
						d.resultValid = 1'b1;
						d.sensorOn = 1'b0;
						d.convCnt = '0;
						d.seq = tcc_pkg::TCC_IDLE;
					end
					else
						d.convCnt = q.convCnt + 36'h1;
				end
				default:
				begin
					d.seq = tcc_pkg::TCC_IDLE;
					d.sensorOn = 1'b0;
				end
			endcase
		end

		// Initial digital trim mapped onto the final digital encoding
		case (q.initDigital)
			2'h1: digitalSel = 5'h01;
			2'h3: digitalSel = 5'h11;
			default: digitalSel = 5'h00;
		endcase
		if (sensingAllowed)
		begin
			analogSel = finalAnalogTrim;
			digitalSel = finalDigitalTrim;
		end
		else
			analogSel = q.initAnalog;
		d.oscAnalog = analogSel;
		d.oscDigital = digitalSel;
		d.oscScaled = 14'(scaledSixteenths);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.temp_sense_enable <= `TCC_TSE_RESET;
			q.bse <= `TCC_BSE_RESET;
			q.bsr <= `TCC_BSR_RESET;
		end
		else
			q <= d;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign sensorOn = q.sensorOn;
	assign tempResult = q.tempResult;
	assign compActive = q.compActive;
	assign oscAnalogCode = q.oscAnalog;
	assign oscDigitalCode = q.oscDigital;
	assign oscAnalogScaled = q.oscScaled;

endmodule // tcc_top

/* rtl/tcc_trim_scale.sv */
`timescale 1ns/1ns
`include "tcc_params.svh"

module tcc_trim_scale
(
	// Codes
	input wire logic [5:0] trimCode,
	input wire logic [4:0] gainCode,
	// Results
	output logic signed [6:0] trimPpm,
	output logic [5:0] gainSixteenths,
	output logic signed [13:0] scaledSixteenths
);

	always_comb
	begin
		// Code 0 is +32, top bit set counts down to -31
		trimPpm = signed'(7'(`TCC_TRIM_ZERO - {1'b0, trimCode}));
		if (gainCode[`TCC_GAIN_MSB])
			gainSixteenths = 6'(`TCC_GAIN_UNITY + 6'h01 + {2'h0, gainCode[3:0]});
		else if (gainCode[3])
			// Codes above 01000 have no defined step; clamp to half
			gainSixteenths = `TCC_GAIN_MIN;
		else
			gainSixteenths = 6'(`TCC_GAIN_UNITY - {3'h0, gainCode[2:0]});
		scaledSixteenths = 14'(trimPpm * signed'({1'b0, gainSixteenths}));
	end

endmodule // tcc_trim_scale
